// ==== core/sfs_pkg.sv ====
// Purpose: shared constants and types of the steering fault supervisor
// Assumes: 40 MHz clock, 12-bit voltage words from a same-clock ADC
// Notes:   register offsets are word addresses on the plain register port
package sfs_pkg;
	// clock and periodic evaluation rate
	localparam int CLK_MHZ       = 40;
	localparam int TICK_US       = 1000;
	localparam int TICK_CYCLES   = TICK_US * CLK_MHZ;
	localparam int CAN_WAIT_MS   = 80;
	localparam int CAN_WAIT_TICKS = (CAN_WAIT_MS * 1000) / TICK_US;
	// voltage scaling: one ADC count is VOLT_LSB_MV millivolts
	localparam int VOLT_LSB_MV   = 25;
	localparam int OPEN_DIFF_MV  = 5000;
	localparam int CLOSE_DIFF_MV = 2000;
	localparam logic [11:0] OPEN_DIFF_CNT  = 12'(OPEN_DIFF_MV / VOLT_LSB_MV);
	localparam logic [11:0] CLOSE_DIFF_CNT = 12'(CLOSE_DIFF_MV / VOLT_LSB_MV);
	// register map (word addresses)
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_LIMIT0 = 4'h1; // 1..8: upper,lower per channel
	localparam logic [3:0] REG_STATUS = 4'h9;
	localparam logic [3:0] REG_REPORT = 4'ha;
	// control field positions
	localparam int CTRL_CTYPE_LSB = 0;  // [1:0] contactor control type
	localparam int CTRL_CHK_EN    = 2;  // contactor checks enable
	localparam int CTRL_CMD_LSB   = 4;  // [6:4] command input device
	localparam int CTRL_FB_LSB    = 8;  // [10:8] position feedback device
	localparam int CTRL_CAN_REQ   = 12; // CAN required
	localparam logic [15:0] CTRL_RESET  = 16'h0000;
	localparam logic [11:0] UPPER_RESET = 12'hfff;
	localparam logic [11:0] LOWER_RESET = 12'h000;
	// contactor states and selections
	localparam logic [1:0] CONT_CLOSING = 2'h1;
	localparam logic [1:0] CONT_CLOSED  = 2'h2;
	localparam logic [1:0] CTYPE_CHECKED = 2'h1;
	// fault bit positions, also priority order (lowest index wins)
	localparam int F_NVM = 0;
	localparam int F_NOCLOSE = 1;
	localparam int F_OPENED = 2;
	localparam int F_CMDA = 3;
	localparam int F_CMDB = 4;
	localparam int F_FBA = 5;
	localparam int F_FBB = 6;
	localparam int F_CAN = 7;
	localparam int NFAULT = 8;
	localparam logic [7:0] FLASH_NVM = 8'h2e; // 46, arbitrary slot
	localparam logic [1:0] TRACTION_STOP = 2'h1;

	typedef enum logic [2:0] {
		SA_NONE          = 3'h0,
		SA_WARN_SHUTDOWN = 3'h1,
		SA_SHUTDOWN      = 3'h2,
		SA_HOLD_SHUTDOWN = 3'h3,
		SA_WARN_DROP     = 3'h4
	} sfs_steer_type;

	typedef struct packed {
		logic [7:0]    flash;
		logic [3:0]    sub;
		sfs_steer_type steer;
		logic [1:0]    traction;
	} sfs_report_type;

	typedef struct packed {
		logic [11:0] cmdA;
		logic [11:0] cmdB;
		logic [11:0] fbA;
		logic [11:0] fbB;
		logic [11:0] capBank;
		logic [11:0] keyVolt;
	} sfs_analog_type;
endpackage

// ==== core/sfs_supervisor.sv ====
// Purpose: latches steering controller faults and reports flash codes
// Assumes: analog words, contactor state, CAN state come from clock domain;
//          keyswitch and interlock are pins and are synchronised here
// Notes:   faults are evaluated once per tick; checksum error latches at once
// Operation
// - contactor faults only with control type 1 and checks enabled
// - closed state: bank and keyswitch differ over 5 V raises opened fault
// - closing state: difference over 2 V raises did-not-close fault
// - opened fault: code 39/1, warning then shutdown, traction stop
// - did-not-close fault: code 39/5, immediate shutdown, traction stop
// - command device 0,2,3: command A out of window gives 41/1, hold
// - command device 0,2,3: command B out of window gives 42/1, hold
// - feedback device 0,2,3: feedback A out of window gives 43/1, hold
// - feedback device 0,2,3: feedback B out of window gives 44/1, hold
// - interlock on 80 ms without CAN operational gives 45/1
// - CAN check only if required; warns, drops fault output, stop
// - stored parameter checksum mismatch: shutdown, traction stop
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/10ps
module sfs_supervisor import sfs_pkg::*; #(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input  wire logic           clock,          // 40 MHz clock
	input  wire logic           rst,            // synchronous reset
	input  wire logic [3:0]     regAddr,        // register word address
	input  wire logic [15:0]    regWrData,      // register write data
	input  wire logic           regWr,          // write strobe
	input  wire logic           regRd,          // read strobe
	output logic [15:0]         regRdData,      // read data, cycle after
	input  wire logic           keyswitchInput, // keyswitch pin
	input  wire logic           interlockIn,    // interlock pin
	input  wire sfs_analog_type analogIn,       // sampled voltages
	input  wire logic [1:0]     contactorState, // 0 open,1 closing,2 closed
	input  wire logic           canOperational, // NMT state operational
	input  wire logic           checksumBad,    // checksum mismatch pulse
	output logic [NFAULT-1:0]   faultLatched,   // latched fault bits
	output sfs_report_type      faultReport,    // active code and actions
	output logic                faultOutputOn,  // fault output driver on
	output logic                anyFault        // any fault latched
);
	// window check shared by the four analog channels
	function automatic logic outOfWindow(input logic [11:0] v,
		input logic [11:0] hi, input logic [11:0] lo);
		outOfWindow = (v > hi) || (v < lo);
	endfunction

	// absolute difference of two voltage words
	function automatic logic [11:0] absDiff(input logic [11:0] a,
		input logic [11:0] b);
		absDiff = (a > b) ? (a - b) : (b - a);
	endfunction

	// device selections 0, 2 and 3 carry analog channels
	function automatic logic analogSel(input logic [2:0] sel);
		analogSel = (sel == 3'h0) || (sel == 3'h2) || (sel == 3'h3);
	endfunction

	logic [1:0]          ksiSync_q, ksiSync_d;
	logic [1:0]          ilkSync_q, ilkSync_d;
	logic                ksiPrev_q, ksiPrev_d;
	logic [31:0]         tickCnt_q, tickCnt_d;
	logic                tick_q,    tick_d;
	logic [7:0]          ilkCnt_q,  ilkCnt_d;
	logic [15:0]         ctrl_q,    ctrl_d;
	logic [11:0]         limit_q [8];
	logic [11:0]         limit_d [8];
	logic [NFAULT-1:0]   fault_q,   fault_d;
	logic [NFAULT-1:0]   newFault;
	sfs_report_type      report_q,  report_d;
	logic                drvOn_q,   drvOn_d;
	logic                any_q,     any_d;
	logic [15:0]         rdData_q,  rdData_d;
	logic                ksiOn;
	logic                ksiRise;
	logic                ilkOn;
	logic                contChecks;

	// pins pass two flops; only the second stage is read by logic
	always_comb begin
		ksiSync_d = {ksiSync_q[0], keyswitchInput};
		ilkSync_d = {ilkSync_q[0], interlockIn};
		ksiPrev_d = ksiSync_q[1];
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ksiSync_q <= 2'h0;
			ilkSync_q <= 2'h0;
			ksiPrev_q <= 1'b0;
		end else begin
			ksiSync_q <= ksiSync_d;
			ilkSync_q <= ilkSync_d;
			ksiPrev_q <= ksiPrev_d;
		end
	end

	assign ksiOn   = ksiSync_q[1];
	assign ilkOn   = ilkSync_q[1];
	assign ksiRise = ksiOn && !ksiPrev_q; // off then on again

	// periodic evaluation tick; one-cycle enable pulse
	always_comb begin
		tick_d    = 1'b0;
		tickCnt_d = tickCnt_q + 32'h1;
		if (tickCnt_q >= 32'(TICK_LEN - 1)) begin
			tickCnt_d = 32'h0;
			tick_d    = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			tickCnt_q <= 32'h0;
			tick_q    <= 1'b0;
		end else begin
			tickCnt_q <= tickCnt_d;
			tick_q    <= tick_d;
		end
	end

	// interlock-on time in ticks; saturates so it never wraps
	always_comb begin
		ilkCnt_d = ilkCnt_q;
		if (!ilkOn) begin
			ilkCnt_d = 8'h0;
		end else if (tick_q && ilkCnt_q < 8'(CAN_WAIT_TICKS)) begin
			ilkCnt_d = ilkCnt_q + 8'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ilkCnt_q <= 8'h0;
		end else begin
			ilkCnt_q <= ilkCnt_d;
		end
	end

	// software-written configuration
	always_comb begin
		ctrl_d = ctrl_q;
		for (int i = 0; i < 8; i++) begin
			limit_d[i] = limit_q[i];
		end
		if (regWr) begin
			if (regAddr == REG_CTRL) begin
				ctrl_d = regWrData;
			end
			for (int i = 0; i < 8; i++) begin
				if (regAddr == REG_LIMIT0 + 4'(i)) begin
					limit_d[i] = regWrData[11:0];
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
			for (int i = 0; i < 8; i++) begin
				limit_q[i] <= i[0] ? LOWER_RESET : UPPER_RESET;
			end
		end else begin
			ctrl_q <= ctrl_d;
			for (int i = 0; i < 8; i++) begin
				limit_q[i] <= limit_d[i];
			end
		end
	end

	assign contChecks =
		(ctrl_q[CTRL_CTYPE_LSB +: 2] == CTYPE_CHECKED) &&
		ctrl_q[CTRL_CHK_EN];

	// raw fault conditions; tick-gated except the checksum pulse
	always_comb begin
		newFault = '0;
		newFault[F_NVM] = checksumBad;
		if (tick_q) begin
			newFault[F_OPENED] = contChecks &&
				(contactorState == CONT_CLOSED) &&
				(absDiff(analogIn.capBank, analogIn.keyVolt) >
				OPEN_DIFF_CNT);
			newFault[F_NOCLOSE] = contChecks &&
				(contactorState == CONT_CLOSING) &&
				(absDiff(analogIn.capBank, analogIn.keyVolt) >
				CLOSE_DIFF_CNT);
			newFault[F_CMDA] = analogSel(ctrl_q[CTRL_CMD_LSB +: 3]) &&
				outOfWindow(analogIn.cmdA, limit_q[0], limit_q[1]);
			newFault[F_CMDB] = analogSel(ctrl_q[CTRL_CMD_LSB +: 3]) &&
				outOfWindow(analogIn.cmdB, limit_q[2], limit_q[3]);
			newFault[F_FBA] = analogSel(ctrl_q[CTRL_FB_LSB +: 3]) &&
				outOfWindow(analogIn.fbA, limit_q[4], limit_q[5]);
			newFault[F_FBB] = analogSel(ctrl_q[CTRL_FB_LSB +: 3]) &&
				outOfWindow(analogIn.fbB, limit_q[6], limit_q[7]);
			newFault[F_CAN] = ctrl_q[CTRL_CAN_REQ] &&
				(ilkCnt_q >= 8'(CAN_WAIT_TICKS)) &&
				!canOperational;
		end
	end

	// latch: a keyswitch cycle clears, but a new set in that cycle wins
	always_comb begin
		fault_d = (ksiRise ? '0 : fault_q) | newFault;
	end

	// highest-priority latched fault picks the reported codes
	always_comb begin
		report_d = '{flash: 8'h0, sub: 4'h0, steer: SA_NONE,
			traction: 2'h0};
		for (int i = NFAULT - 1; i >= 0; i--) begin
			if (fault_d[i]) begin
				report_d.traction = TRACTION_STOP;
				unique case (i)
				F_NVM: begin
					report_d.flash = FLASH_NVM;
					report_d.sub   = 4'h1;
					report_d.steer = SA_SHUTDOWN;
				end
				F_NOCLOSE: begin
					report_d.flash = 8'h27;
					report_d.sub   = 4'h5;
					report_d.steer = SA_SHUTDOWN;
				end
				F_OPENED: begin
					report_d.flash = 8'h27;
					report_d.sub   = 4'h1;
					report_d.steer = SA_WARN_SHUTDOWN;
				end
				F_CAN: begin
					report_d.flash = 8'h2d;
					report_d.sub   = 4'h1;
					report_d.steer = SA_WARN_DROP;
				end
				default: begin
					// analog channels 41..44 in bit order
					report_d.flash = 8'h29 + 8'(i - F_CMDA);
					report_d.sub   = 4'h1;
					report_d.steer = SA_HOLD_SHUTDOWN;
				end
				endcase
			end
		end
		any_d   = |fault_d;
		drvOn_d = ksiOn && !fault_d[F_CAN];
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			fault_q  <= '0;
			report_q <= '{flash: 8'h0, sub: 4'h0, steer: SA_NONE,
				traction: 2'h0};
			any_q    <= 1'b0;
			drvOn_q  <= 1'b0;
		end else begin
			fault_q  <= fault_d;
			report_q <= report_d;
			any_q    <= any_d;
			drvOn_q  <= drvOn_d;
		end
	end

	// read mux; unmapped addresses and idle cycles read zero
	always_comb begin
		rdData_d = 16'h0;
		if (regRd) begin
			if (regAddr == REG_CTRL) begin
				rdData_d = ctrl_q;
			end else if (regAddr == REG_STATUS) begin
				rdData_d = {8'h0, fault_q};
			end else if (regAddr == REG_REPORT) begin
				rdData_d = {report_q.sub, report_q.flash, 4'h0};
				rdData_d[2:0] = report_q.steer;
			end
			for (int i = 0; i < 8; i++) begin
				if (regAddr == REG_LIMIT0 + 4'(i)) begin
					rdData_d = {4'h0, limit_q[i]};
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdData_q <= 16'h0;
		end else begin
			rdData_q <= rdData_d;
		end
	end

	assign regRdData     = rdData_q;
	assign faultLatched  = fault_q;
	assign faultReport   = report_q;
	assign faultOutputOn = drvOn_q;
	assign anyFault      = any_q;
endmodule

// ==== test/sfs_supervisor_asserts.sv ====
// Purpose: port-level checks of the steering fault supervisor
// Assumes: control word is shadowed from register writes
// Notes:   limits are not shadowed; window faults are judged by the bench
`timescale 1ns/10ps
module sfs_supervisor_chk import sfs_pkg::*; (
	input wire logic              clock,          // clock
	input wire logic              rst,            // reset
	input wire logic [3:0]        regAddr,        // address
	input wire logic [15:0]       regWrData,      // write data
	input wire logic              regWr,          // write strobe
	input wire logic              keyswitchInput, // keyswitch pin
	input wire sfs_analog_type    analogIn,       // voltages
	input wire logic [1:0]        contactorState, // contactor state
	input wire logic [NFAULT-1:0] faultLatched,   // faults
	input wire sfs_report_type    faultReport,    // report
	input wire logic              faultOutputOn,  // fault output
	input wire logic              anyFault        // any fault
);
	logic [15:0] ctrl_q;
	logic [11:0] diff;
	// shadow of the control word; a write lands one cycle later
	always_ff @(posedge clock) begin
		if (rst)
			ctrl_q <= CTRL_RESET;
		else if (regWr && regAddr == REG_CTRL)
			ctrl_q <= regWrData;
	end
	// magnitude of bank against keyswitch, either sign
	assign diff = (analogIn.capBank > analogIn.keyVolt) ?
		analogIn.capBank - analogIn.keyVolt :
		analogIn.keyVolt - analogIn.capBank;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_contEn;
		$past(ctrl_q[1:0]) == CTYPE_CHECKED && $past(ctrl_q[CTRL_CHK_EN]);
	endsequence
	sequence s_state(logic [1:0] st, logic [11:0] lim);
		$past(contactorState) == st && $past(diff) > lim;
	endsequence
	property p_contEn;
		$rose(faultLatched[F_OPENED]) || $rose(faultLatched[F_NOCLOSE])
			|-> s_contEn;
	endproperty
	a_contEn: assert property (p_contEn) else $error("contactor check off");
	property p_opened;
		$rose(faultLatched[F_OPENED]) |-> s_state(CONT_CLOSED, OPEN_DIFF_CNT);
	endproperty
	a_opened: assert property (p_opened) else $error("opened without cause");
	property p_noClose;
		$rose(faultLatched[F_NOCLOSE]) |->
			s_state(CONT_CLOSING, CLOSE_DIFF_CNT);
	endproperty
	a_noClose: assert property (p_noClose) else $error("no-close no cause");
	property p_rep39a;
		faultLatched[2:0] == 3'h4 |-> faultReport ==
			{8'h27, 4'h1, SA_WARN_SHUTDOWN, TRACTION_STOP};
	endproperty
	a_rep39a: assert property (p_rep39a) else $error("opened report");
	property p_rep39b;
		faultLatched[1:0] == 2'h2 |-> faultReport ==
			{8'h27, 4'h5, SA_SHUTDOWN, TRACTION_STOP};
	endproperty
	a_rep39b: assert property (p_rep39b) else $error("no-close report");
	property p_cmdSel;
		$rose(faultLatched[F_CMDA]) |->
			$past(ctrl_q[6:4]) inside {3'h0, 3'h2, 3'h3};
	endproperty
	a_cmdSel: assert property (p_cmdSel) else $error("command device off");
	property p_canOut; faultLatched[F_CAN] |-> !faultOutputOn; endproperty
	a_canOut: assert property (p_canOut) else $error("fault output on");
	// a clear shows four edges after the pin rose, past the synchroniser
	property p_hold;
		|($past(faultLatched) & ~faultLatched) |->
			$past(keyswitchInput, 3) && !$past(keyswitchInput, 4);
	endproperty
	a_hold: assert property (p_hold) else $error("fault cleared early");
	property p_any; anyFault == |faultLatched; endproperty
	a_any: assert property (p_any) else $error("any fault mismatch");
endmodule
bind sfs_supervisor sfs_supervisor_chk u_chk (.clock, .rst, .regAddr,
	.regWrData, .regWr, .keyswitchInput, .analogIn, .contactorState,
	.faultLatched, .faultReport, .faultOutputOn, .anyFault);

// ==== test/sfs_plant.sv ====
// Purpose: contactor and capacitor bank at the supervisor's far side
// Assumes: bank follows keyswitch voltage while the tips make contact
// Notes:   stuck and sag inputs let a scenario spoil the contactor
`timescale 1ns/10ps
module sfs_plant import sfs_pkg::*; #(
	parameter int CLOSE_T = 30
) (
	input  wire logic        clock,     // clock
	input  wire logic        closeReq,  // coil command
	input  wire logic        stuck,     // tips never make
	input  wire logic [11:0] bankSag,   // drop across closed tips
	input  wire logic [11:0] keyVolt,   // keyswitch voltage
	output logic [1:0]       contState, // 0 open, 1 closing, 2 closed
	output logic [11:0]      capBank    // bank voltage
);
	int cnt = 0;
	// closing lasts CLOSE_T cycles; a stuck contactor stays closing
	always_ff @(posedge clock) cnt <= closeReq ? cnt + 1 : 0;
	assign contState = !closeReq ? 2'h0 : (stuck || cnt < CLOSE_T) ? 2'h1 : 2'h2;
	// an open bank reads zero, not its last charge
	assign capBank = (contState == 2'h2) ? keyVolt - bankSag :
		(contState == 2'h1 && !stuck) ? keyVolt : 12'h000;
endmodule

// ==== test/tb_steer_fault_supervisor.sv ====
// Purpose: register and fault scenarios for the steering fault supervisor
// Assumes: tick shortened to 10 cycles
// Notes:   every ticks() wait is a whole number of ticks plus a 3-cycle margin
`timescale 1ns/10ps
module tb_steer_fault_supervisor import sfs_pkg::*;;
	logic clock = 0, rst = 1, regWr = 0, regRd = 0, keyswitchInput = 1;
	logic interlockIn = 0, canOperational = 0, checksumBad = 0;
	logic closeReq = 0, stuck = 0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000;
	logic [11:0] volt[4] = '{12'h400, 12'h400, 12'h400, 12'h400};
	logic [11:0] keyVolt = 12'h3c0, bankSag = 12'h000, capBank;
	logic [15:0] regRdData;
	logic [7:0] faultLatched;
	logic [1:0] contState;
	logic faultOutputOn, anyFault;
	sfs_report_type faultReport;
	sfs_analog_type ana;
	int errorCnt = 0, testsRun = 0;
	assign ana = {volt[0], volt[1], volt[2], volt[3], capBank, keyVolt};
	always #12.5 clock = ~clock;
	sfs_plant plant (.clock(clock), .closeReq(closeReq), .stuck(stuck),
		.bankSag(bankSag), .keyVolt(keyVolt), .contState(contState),
		.capBank(capBank));
	sfs_supervisor #(.TICK_LEN(10)) uut (.clock(clock), .rst(rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .keyswitchInput(keyswitchInput),
		.interlockIn(interlockIn), .analogIn(ana), .contactorState(contState),
		.canOperational(canOperational), .checksumBad(checksumBad),
		.faultLatched(faultLatched), .faultReport(faultReport),
		.faultOutputOn(faultOutputOn), .anyFault(anyFault));
	task automatic finalReport();
		$display("checks %0d mismatches %0d", testsRun, errorCnt);
		if (errorCnt == 0 && testsRun > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chkReg(input logic [15:0] got, input logic [15:0] e);
		testsRun++;
		if (got !== e) begin
			errorCnt++;
			$display("[FAIL] %0t word %h expected %h", $time, got, e);
		end
	endtask
	task automatic chkF(input logic [7:0] fl, input sfs_report_type r);
		testsRun++;
		if ({faultLatched, faultReport} !== {fl, r}) begin
			errorCnt++;
			$display("[FAIL] %0t faults %h report %h", $time, faultLatched,
				faultReport);
		end
	endtask
	function automatic sfs_report_type rep(logic [7:0] f, logic [3:0] s,
		sfs_steer_type st);
		return '{f, s, st, TRACTION_STOP};
	endfunction
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clock);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRd <= 1'b0;
		#1 chkReg(regRdData, e);
	endtask
	task automatic ticks(input int n);
		repeat (n * 10 + 3) @(posedge clock);
	endtask
	// benign inputs first, else the next tick would latch again
	task automatic clr(input string name);
		@(posedge clock);
		{closeReq, stuck, interlockIn, canOperational} <= 4'h0;
		bankSag <= 12'h000;
		keyVolt <= 12'h3c0;
		volt <= '{12'h400, 12'h400, 12'h400, 12'h400};
		wr(REG_CTRL, 16'h0000);
		keyswitchInput <= 1'b0;
		repeat (6) @(posedge clock);
		keyswitchInput <= 1'b1;
		repeat (6) @(posedge clock);
		chkF(8'h00, '0);
		$display("test %s done", name);
	endtask
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd(REG_CTRL, CTRL_RESET);
		rd(4'h1, {4'h0, UPPER_RESET});
		rd(4'h2, {4'h0, LOWER_RESET});
		rd(4'hb, 16'h0000);
		wr(REG_STATUS, 16'hffff);
		rd(REG_STATUS, 16'h0000);
		$display("test registers done");
		// bank sag at the 5 V limit, then one count past it
		wr(REG_CTRL, 16'h0005);
		closeReq <= 1'b1;
		bankSag <= OPEN_DIFF_CNT;
		ticks(6);
		chkF(8'h00, '0);
		bankSag <= OPEN_DIFF_CNT + 12'h001;
		ticks(2);
		chkF(8'h04, rep(8'h27, 4'h1, SA_WARN_SHUTDOWN));
		bankSag <= 12'h000;
		ticks(3);
		rd(REG_STATUS, 16'h0004);
		clr("opened");
		wr(REG_CTRL, 16'h0005);
		{closeReq, stuck} <= 2'h3;
		keyVolt <= CLOSE_DIFF_CNT;
		ticks(3);
		chkF(8'h00, '0);
		keyVolt <= CLOSE_DIFF_CNT + 12'h001;
		ticks(2);
		chkF(8'h02, rep(8'h27, 4'h5, SA_SHUTDOWN));
		clr("no close");
		{closeReq, stuck} <= 2'h3;
		foreach (volt[i]) begin
			wr(REG_CTRL, (i == 0) ? 16'h0001 : (i == 1) ? 16'h0004 :
				(i == 2) ? 16'h0006 : 16'h0007);
			ticks(3);
			chkF(8'h00, '0);
		end
		clr("contactor gated");
		for (int ch = 0; ch < 4; ch++) begin
			for (int s = 0; s < 5; s++) begin
				wr(REG_CTRL, 16'((s << CTRL_CMD_LSB) | (s << CTRL_FB_LSB)));
				wr(4'(1 + 2 * ch), 16'h0600);
				wr(4'(2 + 2 * ch), 16'h0200);
				volt[ch] <= s[0] ? 12'h600 : 12'h200;
				ticks(2);
				chkF(8'h00, '0);
				volt[ch] <= s[0] ? 12'h601 : 12'h1ff;
				ticks(2);
				if (s == 1 || s == 4)
					chkF(8'h00, '0);
				else
					chkF(8'(8'h08 << ch), rep(8'(8'h29 + ch), 4'h1,
						SA_HOLD_SHUTDOWN));
				clr("window");
			end
		end
		// operational link, then check off, then a genuine late link
		wr(REG_CTRL, 16'h1000);
		{interlockIn, canOperational} <= 2'h3;
		ticks(85);
		chkF(8'h00, '0);
		wr(REG_CTRL, 16'h0000);
		canOperational <= 1'b0;
		ticks(3);
		chkF(8'h00, '0);
		// let the saturated interlock count clear before arming the check
		interlockIn <= 1'b0;
		ticks(1);
		wr(REG_CTRL, 16'h1000);
		interlockIn <= 1'b1;
		ticks(78);
		chkF(8'h00, '0);
		chkReg({15'h0, faultOutputOn}, 16'h0001);
		ticks(4);
		chkF(8'h80, rep(8'h2d, 4'h1, SA_WARN_DROP));
		chkReg({15'h0, faultOutputOn}, 16'h0000);
		// checksum pulse on top of the link fault wins priority
		@(posedge clock);
		checksumBad <= 1'b1;
		@(posedge clock);
		checksumBad <= 1'b0;
		repeat (2) @(posedge clock);
		chkF(8'h81, rep(FLASH_NVM, 4'h1, SA_SHUTDOWN));
		rd(REG_REPORT, 16'h12e2);
		clr("link and checksum");
		finalReport();
	end
endmodule
